// ### design/buck_seq_pkg.sv
// package for the buck start-up and fault sequencer
// assumes a 200 MHz mclk; analog comparator results arrive as pins
package buck_seq_pkg;
    // clock period in ps
    localparam int unsigned clk_period_ps = 5000;
    // bootstrap hold time in ns and cycles
    localparam int unsigned boot_hold_ns = 200;
    localparam int unsigned boot_hold_cyc = (boot_hold_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
    // current sense blanking and filter times
    localparam int unsigned blank_ns = 120;
    localparam int unsigned blank_cyc = (blank_ns * 1000) / clk_period_ps;
    localparam int unsigned filt_ns = 120;
    localparam int unsigned filt_cyc = (filt_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
    // power-good delay in us, cycles derived
    localparam int unsigned pg_delay_us = 7100;
    localparam int unsigned pg_delay_cyc = (pg_delay_us * 1000) / (clk_period_ps / 1000);
    // retry wait: soft-start charge and discharge cycles
    localparam logic [1:0] retry_cycles = 2'h3;
    // sinking fault low-side blank in switching cycles
    localparam logic [1:0] sink_cycles = 2'h3;
    // counter width for timers
    localparam int unsigned cnt_w = 24;

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        st_wait = 6'h01,
        st_charge = 6'h02,
        st_boot = 6'h04,
        st_ramp = 6'h08,
        st_run = 6'h10,
        st_retry = 6'h20
    } seq_state_t;

    // analog comparator inputs grouped
    typedef struct packed {
        logic supplies_ok;
        logic enable_high;
        logic comp_above_ramp;
        logic ss_at_ref;
        logic ss_low;
        logic ss_high;
        logic out_in_window;
        logic out_over;
        logic out_under;
        logic hs_oc;
        logic ls_src_oc;
        logic ls_sink_oc;
    } analog_in_t;
endpackage : buck_seq_pkg

// ### design/buck_startup_fault_sequencer.sv
// start-up and protection sequencer of a single-phase buck controller
// assumes comparator results from analog circuits, pwm and switch edge from the modulator
//
// Operation
// - start only with supplies and enable good
// - enable sink current on while disabled
// - charge to supply until comp above ramp
// - hold low-side low 200ns after enabling drivers
// - then target margined reference for soft-start
// - done when drivers on and ss near reference
// - power-good reference follows soft-start node
// - power-good only within window with hysteresis
// - no power-good before soft-start completes
// - delay power-good rise, not its fall
// - uv and ov disabled until soft-start done
// - ov: high-side off, low-side on, power_good_output low
// - ov held until clear, beats overcurrent
// - uv only pulls power-good low
// - overcurrent enabled with drivers, every period
// - blank sense 120ns, then filter 120ns
// - low-side sourcing overcurrent raises fault
// - low-side sinking overcurrent raises fault
// - high-side sourcing overcurrent raises fault
// - sourcing fault: gates low, discharge, retry
// - retry wait is three soft-start cycles
// - sinking fault: low-side off three cycles
`timescale 1ns/1ps
`default_nettype none
module buck_startup_fault_sequencer #(
    parameter int unsigned pg_delay = buck_seq_pkg::pg_delay_cyc
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire buck_seq_pkg::analog_in_t ana_in,
    input wire logic pwm_in,
    input wire logic sw_edge,
    output logic high_side_gate_drive,
    output logic low_side_gate_drive,
    output logic power_good_output_n,
    output logic power_good_output_oe_n,
    output logic enable_sink_on,
    output logic charge_to_supply,
    output logic charge_to_reference,
    output logic ss_discharge,
    output logic pg_ref_from_soft_start,
    output logic soft_start_done,
    output logic fault_source_oc
);
    // two-flop synchroniser for all analog inputs
    buck_seq_pkg::analog_in_t sync1_reg;
    buck_seq_pkg::analog_in_t sync2_reg;
    // synchronised inputs, pwm and edge from same-clock modulator
    buck_seq_pkg::analog_in_t a;
    buck_seq_pkg::seq_state_t state_reg, state_next;
    logic [buck_seq_pkg::cnt_w-1:0] tmr_reg; // shared state timer
    logic [1:0] retry_cnt_reg; // soft-start cycles done in retry
    logic retry_rise_reg; // retry cycle direction: 1 charging
    logic [7:0] blank_reg; // sense blanking counter, cycles since switching edge
    logic [7:0] hs_filt_reg, lss_filt_reg, lsk_filt_reg; // filter run lengths
    logic [1:0] sink_cnt_reg; // low-side blank counter
    logic pg_qual_reg; // power-good window state with hysteresis
    logic [buck_seq_pkg::cnt_w-1:0] pg_tmr_reg; // power-good delay count
    logic pg_on_reg; // delayed power-good

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= ana_in;
            sync2_reg <= sync1_reg;
        end
    end
    assign a = sync2_reg;

    // decode
    wire power_ok = a.supplies_ok && a.enable_high;
    wire drivers_on = state_reg == buck_seq_pkg::st_boot || state_reg == buck_seq_pkg::st_ramp
        || state_reg == buck_seq_pkg::st_run;
    wire running = state_reg == buck_seq_pkg::st_run;
    wire ov_act = running && a.out_over;
    wire uv_act = running && a.out_under;
    // overcurrent comparators only count once the blanking time has run out
    wire sense_open = drivers_on && blank_reg >= 8'(buck_seq_pkg::blank_cyc);
    // a filtered fault needs the comparator held for the whole filter time
    wire hs_fault = hs_filt_reg >= 8'(buck_seq_pkg::filt_cyc);
    wire lss_fault = lss_filt_reg >= 8'(buck_seq_pkg::filt_cyc);
    wire lsk_fault = lsk_filt_reg >= 8'(buck_seq_pkg::filt_cyc);
    // overvoltage masks both overcurrent responses while it holds
    wire src_fault = (hs_fault || lss_fault) && !ov_act;
    wire sink_start = lsk_fault && !ov_act && sink_cnt_reg == 2'h0;
    wire boot_done = tmr_reg >= buck_seq_pkg::cnt_w'(buck_seq_pkg::boot_hold_cyc - 1);

    // next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            buck_seq_pkg::st_wait: begin
                if (power_ok) state_next = buck_seq_pkg::st_charge;
            end
            buck_seq_pkg::st_charge: begin
                if (a.comp_above_ramp) state_next = buck_seq_pkg::st_boot;
            end
            buck_seq_pkg::st_boot: begin
                if (boot_done) state_next = buck_seq_pkg::st_ramp;
            end
            buck_seq_pkg::st_ramp: begin
                if (a.ss_at_ref) state_next = buck_seq_pkg::st_run;
            end
            buck_seq_pkg::st_run: begin
                state_next = buck_seq_pkg::st_run;
            end
            buck_seq_pkg::st_retry: begin
                if (retry_cnt_reg == buck_seq_pkg::retry_cycles && !retry_rise_reg && a.ss_low)
                    state_next = buck_seq_pkg::st_charge;
            end
            default: state_next = buck_seq_pkg::st_wait;
        endcase
        if (drivers_on && src_fault) state_next = buck_seq_pkg::st_retry;
        if (!power_ok) state_next = buck_seq_pkg::st_wait;
    end

    // state and boot timer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= buck_seq_pkg::st_wait;
            tmr_reg <= '0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= (state_next != state_reg) ? '0 : tmr_reg + 1'b1;
        end
    end

    // retry: count soft-start charge/discharge cycles
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            retry_cnt_reg <= 2'h0;
            retry_rise_reg <= 1'b0;
        end else if (state_reg != buck_seq_pkg::st_retry) begin
            retry_cnt_reg <= 2'h0;
            retry_rise_reg <= 1'b0; // first discharge
        end else if (retry_rise_reg && a.ss_high) begin
            retry_rise_reg <= 1'b0; // top reached, discharge
        end else if (!retry_rise_reg && a.ss_low && retry_cnt_reg != buck_seq_pkg::retry_cycles) begin
            retry_rise_reg <= 1'b1; // start the next full charge
            retry_cnt_reg <= retry_cnt_reg + 2'h1;
        end
    end

    // blanking counter restarts on each switching edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            blank_reg <= 8'h00;
        end else if (!drivers_on || sw_edge) begin
            blank_reg <= 8'h00;
        end else if (blank_reg != 8'hff) begin
            blank_reg <= blank_reg + 8'h01;
        end
    end

    // filters: comparator must hold for the filter time
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hs_filt_reg <= 8'h00;
            lss_filt_reg <= 8'h00;
            lsk_filt_reg <= 8'h00;
        end else begin
            hs_filt_reg <= (sense_open && pwm_in && a.hs_oc) ? hs_filt_reg + {7'h00, !hs_fault} : 8'h00;
            lss_filt_reg <= (sense_open && !pwm_in && a.ls_src_oc) ? lss_filt_reg + {7'h00, !lss_fault} : 8'h00;
            lsk_filt_reg <= (sense_open && !pwm_in && a.ls_sink_oc) ? lsk_filt_reg + {7'h00, !lsk_fault} : 8'h00;
        end
    end

    // sinking fault: count switching edges where pwm rises, with low-side off
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sink_cnt_reg <= 2'h0;
        end else if (!drivers_on || ov_act) begin
            sink_cnt_reg <= 2'h0;
        end else if (sink_start) begin
            sink_cnt_reg <= buck_seq_pkg::sink_cycles;
        end else if (sink_cnt_reg != 2'h0 && sw_edge && pwm_in) begin
            sink_cnt_reg <= sink_cnt_reg - 2'h1;
        end
    end

    // power-good window hysteresis: in window enters, out window leaves
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pg_qual_reg <= 1'b0;
        end else if (!running || ov_act || uv_act || !a.out_in_window) begin
            pg_qual_reg <= 1'b0;
        end else begin
            pg_qual_reg <= 1'b1;
        end
    end

    // power-good delay on rise only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pg_tmr_reg <= '0;
            pg_on_reg <= 1'b0;
        end else if (!pg_qual_reg || !running || ov_act || uv_act) begin
            pg_tmr_reg <= '0;
            pg_on_reg <= 1'b0;
        end else if (pg_tmr_reg >= buck_seq_pkg::cnt_w'(pg_delay - 1)) begin
            pg_on_reg <= 1'b1;
        end else begin
            pg_tmr_reg <= pg_tmr_reg + 1'b1;
        end
    end

    // gate and status outputs, all registered
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            high_side_gate_drive <= 1'b0;
            low_side_gate_drive <= 1'b0;
            power_good_output_n <= 1'b0;
            power_good_output_oe_n <= 1'b0;
            enable_sink_on <= 1'b1;
            charge_to_supply <= 1'b0;
            charge_to_reference <= 1'b0;
            ss_discharge <= 1'b1;
            pg_ref_from_soft_start <= 1'b1;
            soft_start_done <= 1'b0;
            fault_source_oc <= 1'b0;
        end else begin
            if (ov_act) begin
                high_side_gate_drive <= 1'b0;
                low_side_gate_drive <= 1'b1;
            end else if (state_next == buck_seq_pkg::st_boot || state_next == buck_seq_pkg::st_ramp
                || state_next == buck_seq_pkg::st_run) begin
                high_side_gate_drive <= pwm_in && state_next != buck_seq_pkg::st_boot;
                low_side_gate_drive <= !pwm_in && state_next != buck_seq_pkg::st_boot
                    && !sink_start && sink_cnt_reg == 2'h0;
            end else begin
                high_side_gate_drive <= 1'b0;
                low_side_gate_drive <= 1'b0;
            end
            // open-drain: oe_n low pulls the pin low
            power_good_output_n <= 1'b0;
            // release only while the next state still runs, so the fall has no lag
            power_good_output_oe_n <= pg_on_reg && state_next == buck_seq_pkg::st_run && a.out_in_window
                && !ov_act && !uv_act;
            enable_sink_on <= state_next == buck_seq_pkg::st_wait;
            charge_to_supply <= state_next == buck_seq_pkg::st_charge
                || (state_next == buck_seq_pkg::st_retry && retry_rise_reg);
            charge_to_reference <= state_next == buck_seq_pkg::st_boot || state_next == buck_seq_pkg::st_ramp
                || state_next == buck_seq_pkg::st_run;
            ss_discharge <= state_next == buck_seq_pkg::st_wait
                || (state_next == buck_seq_pkg::st_retry && !retry_rise_reg);
            pg_ref_from_soft_start <= 1'b1;
            soft_start_done <= state_next == buck_seq_pkg::st_run;
            fault_source_oc <= state_next == buck_seq_pkg::st_retry;
        end
    end

    // checks
    property p_no_start; @(posedge mclk) disable iff (!resetn)
        (state_reg == buck_seq_pkg::st_wait && !power_ok) |=> state_reg == buck_seq_pkg::st_wait; endproperty
    a_no_start: assert property (p_no_start) else $error("start without power ok");
    property p_sink_en; @(posedge mclk) disable iff (!resetn)
        state_reg == buck_seq_pkg::st_wait && power_ok |=> !enable_sink_on; endproperty
    a_sink_en: assert property (p_sink_en) else $error("enable sink not released");
    sequence s_boot_entry; state_reg == buck_seq_pkg::st_charge ##1 state_reg == buck_seq_pkg::st_boot; endsequence
    property p_boot_hold; @(posedge mclk) disable iff (!resetn)
        s_boot_entry |-> (!low_side_gate_drive || ov_act)[*8]; endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("low side early");
    property p_pg_after_ss; @(posedge mclk) disable iff (!resetn)
        power_good_output_oe_n |-> $past(running); endproperty
    a_pg_after_ss: assert property (p_pg_after_ss) else $error("power good before soft start");
    property p_pg_fall; @(posedge mclk) disable iff (!resetn)
        running && a.out_over |=> power_good_output_oe_n == 1'b0; endproperty
    a_pg_fall: assert property (p_pg_fall) else $error("power good not dropped on ov");
    property p_ov; @(posedge mclk) disable iff (!resetn)
        ov_act |=> low_side_gate_drive && !high_side_gate_drive; endproperty
    a_ov: assert property (p_ov) else $error("ov response wrong");
    property p_src; @(posedge mclk) disable iff (!resetn)
        drivers_on && src_fault && power_ok |=> ##1 !high_side_gate_drive && !low_side_gate_drive && ss_discharge; endproperty
    a_src: assert property (p_src) else $error("sourcing fault response wrong");
    property p_sink; @(posedge mclk) disable iff (!resetn)
        sink_start && power_ok && !src_fault |=> !low_side_gate_drive; endproperty
    a_sink: assert property (p_sink) else $error("low side not blanked");
    property p_wait; @(posedge mclk) disable iff (!resetn)
        !power_ok |=> state_reg == buck_seq_pkg::st_wait ##1 !high_side_gate_drive; endproperty
    a_wait: assert property (p_wait) else $error("not back to wait");
    // retry leaves for a fresh soft-start only after the third full cycle
    property p_retry_exit; @(posedge mclk) disable iff (!resetn)
        state_reg == buck_seq_pkg::st_retry && state_next == buck_seq_pkg::st_charge
        |-> retry_cnt_reg == buck_seq_pkg::retry_cycles; endproperty
    a_retry_exit: assert property (p_retry_exit) else $error("retry left early");
    // sensing stays blind right after a switching edge
    property p_blank; @(posedge mclk) disable iff (!resetn)
        sw_edge |=> !sense_open; endproperty
    a_blank: assert property (p_blank) else $error("sense open after switching edge");
    // undervoltage drops power good at the next edge
    property p_uv; @(posedge mclk) disable iff (!resetn)
        uv_act |=> !power_good_output_oe_n; endproperty
    a_uv: assert property (p_uv) else $error("power good kept on uv");
endmodule : buck_startup_fault_sequencer
`default_nettype wire

// ### dv/buck_far_side_model.sv
// far-side model: soft-start node, error amplifier and the pwm modulator
// assumes the charger controls come from the sequencer on the same mclk
`timescale 1ns/1ps
`default_nettype none
module buck_far_side_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic charge_to_supply,
    input wire logic charge_to_reference,
    input wire logic ss_discharge,
    output logic comp_above_ramp,
    output logic ss_at_ref,
    output logic ss_low,
    output logic ss_high,
    output logic pwm_in,
    output logic sw_edge
);
    int ss_lvl; // soft-start node level, 0 to 100
    int ph; // position in the switching half period
    // node moves one step a cycle toward the chosen target
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ss_lvl <= 0;
            ph <= 0;
            pwm_in <= 1'b0;
            sw_edge <= 1'b0;
        end else begin
            ph <= (ph == 79) ? 0 : ph + 1;
            sw_edge <= (ph == 79);
            if (ph == 79) pwm_in <= !pwm_in;
            if (ss_discharge && ss_lvl > 0) ss_lvl <= ss_lvl - 1;
            else if (charge_to_supply && ss_lvl < 100) ss_lvl <= ss_lvl + 1;
            else if (charge_to_reference && ss_lvl != 50) ss_lvl <= ss_lvl + ((ss_lvl < 50) ? 1 : -1);
        end
    end
    // comparator levels seen by the sequencer
    assign comp_above_ramp = (ss_lvl >= 30);
    assign ss_at_ref = charge_to_reference && ss_lvl >= 48 && ss_lvl <= 52;
    assign ss_low = (ss_lvl == 0);
    assign ss_high = (ss_lvl == 100);
endmodule : buck_far_side_model
`default_nettype wire

// ### dv/tb_top.sv
// testbench for the buck start-up and fault sequencer
// assumes the far-side model supplies soft-start and pwm, bench drives the rest
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int unsigned pg_cyc = 20; // shortened power-good delay
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic s_ok, en, win, ov, uv, hs, lsrc, lsnk; // bench-driven comparators
    wire logic comp, at_ref, ss_lo, ss_hi, pwm, swe;
    logic hsg, lsg, pg_n, oe_n, sink_on, c_sup, c_ref, dis, pgref, done, foc;
    buck_seq_pkg::analog_in_t ana;
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;
    int n, k;
    assign ana = {s_ok, en, comp, at_ref, ss_lo, ss_hi, win, ov, uv, hs, lsrc, lsnk};
    always #2.5 mclk = !mclk;
    buck_far_side_model i_buck_far_side_model (.mclk(mclk), .resetn(resetn), .charge_to_supply(c_sup),
        .charge_to_reference(c_ref), .ss_discharge(dis), .comp_above_ramp(comp), .ss_at_ref(at_ref),
        .ss_low(ss_lo), .ss_high(ss_hi), .pwm_in(pwm), .sw_edge(swe));
    buck_startup_fault_sequencer #(.pg_delay(pg_cyc)) i_buck_startup_fault_sequencer (.mclk(mclk),
        .resetn(resetn), .ana_in(ana), .pwm_in(pwm), .sw_edge(swe), .high_side_gate_drive(hsg),
        .low_side_gate_drive(lsg), .power_good_output_n(pg_n), .power_good_output_oe_n(oe_n),
        .enable_sink_on(sink_on), .charge_to_supply(c_sup), .charge_to_reference(c_ref),
        .ss_discharge(dis), .pg_ref_from_soft_start(pgref), .soft_start_done(done), .fault_source_oc(foc));
    // verdict and end of run
    task automatic report_and_stop();
        if (mismatches == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    // one comparison
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // outputs held in reset
    task automatic t_reset();
        chk(oe_n === 1'b0 && pg_n === 1'b0 && hsg === 1'b0 && lsg === 1'b0, "reset gates");
        chk(sink_on === 1'b1 && dis === 1'b1 && pgref === 1'b1, "reset sink");
    endtask : t_reset
    // start-up with window already good and a false overvoltage
    task automatic t_start();
        s_ok = 1'b1;
        win = 1'b1;
        ov = 1'b1;
        repeat (20) @(negedge mclk);
        chk(c_sup === 1'b0, "charge without enable");
        en = 1'b1;
        for (n = 0; n < 10 && c_sup !== 1'b1; n++) @(negedge mclk);
        chk(c_sup === 1'b1, "no charge");
        while (comp !== 1'b1) begin
            chk(lsg === 1'b0 && hsg === 1'b0, "gates before comp");
            @(negedge mclk);
        end
        ov = 1'b0;
        for (n = 0; n < 300 && lsg !== 1'b1; n++) @(negedge mclk);
        chk(n >= 40, "boot hold short");
        for (n = 0; n < 400 && done !== 1'b1; n++) begin
            chk(oe_n === 1'b0, "pg before done");
            @(negedge mclk);
        end
        chk(done === 1'b1 && c_ref === 1'b1 && at_ref === 1'b1, "soft start");
        chk(sink_on === 1'b0, "sink still on");
    endtask : t_start
    // power-good delay, undervoltage, overvoltage priority
    task automatic t_pg();
        win = 1'b0;
        repeat (5) @(negedge mclk);
        win = 1'b1;
        repeat (pg_cyc) begin
            chk(oe_n === 1'b0, "pg early");
            @(negedge mclk);
        end
        repeat (8) @(negedge mclk);
        chk(oe_n === 1'b1, "pg late");
        uv = 1'b1;
        repeat (4) @(negedge mclk);
        chk(oe_n === 1'b0 && foc === 1'b0 && done === 1'b1, "uv");
        uv = 1'b0;
        ov = 1'b1;
        lsrc = 1'b1;
        repeat (4) @(negedge mclk);
        repeat (200) begin
            chk(hsg === 1'b0 && lsg === 1'b1 && oe_n === 1'b0 && foc === 1'b0, "ov");
            @(negedge mclk);
        end
        lsrc = 1'b0;
        repeat (4) @(negedge mclk);
        ov = 1'b0;
        repeat (4) @(negedge mclk);
        chk(foc === 1'b0 && done === 1'b1, "ov release");
    endtask : t_pg
    // sinking overcurrent blanks the low side for three cycles
    task automatic t_sink();
        while (!(pwm === 1'b0 && swe === 1'b1)) @(negedge mclk);
        lsnk = 1'b1;
        repeat (40) @(negedge mclk);
        chk(lsg === 1'b1, "sink fault early");
        repeat (20) @(negedge mclk);
        chk(lsg === 1'b0 && foc === 1'b0, "sink fault");
        lsnk = 1'b0;
        for (n = 0; n < 900 && lsg !== 1'b1; n++) @(negedge mclk);
        chk(n > 250 && n < 700, "sink length");
    endtask : t_sink
    // sourcing overcurrent and hiccup retry
    task automatic t_src(input logic high_side);
        while (done !== 1'b1) @(negedge mclk);
        while (!(pwm === high_side && swe === 1'b1)) @(negedge mclk);
        hs = high_side;
        lsrc = !high_side;
        repeat (60) @(negedge mclk);
        chk(foc === 1'b1 && hsg === 1'b0 && lsg === 1'b0, "src fault");
        chk(dis === 1'b1 && oe_n === 1'b0, "src discharge");
        hs = 1'b0;
        lsrc = 1'b0;
        k = 0;
        for (n = 0; n < 3000 && foc === 1'b1; n++) begin
            @(negedge mclk);
            if (ss_hi === 1'b1 && c_sup === 1'b1 && foc === 1'b1) k++;
            while (ss_hi === 1'b1 && foc === 1'b1) @(negedge mclk);
        end
        chk(k == 3, "retry count");
        for (n = 0; n < 10 && c_sup !== 1'b1; n++) @(negedge mclk);
        chk(c_sup === 1'b1, "no restart");
    endtask : t_src
    // loss of enable drops everything
    task automatic t_en();
        while (done !== 1'b1) @(negedge mclk);
        en = 1'b0;
        repeat (4) @(negedge mclk);
        chk(sink_on === 1'b1 && hsg === 1'b0 && lsg === 1'b0 && oe_n === 1'b0, "enable loss");
        chk(pg_n === 1'b0 && pgref === 1'b1, "pg pin data");
    endtask : t_en
    // main sequence
    initial begin
        {s_ok, en, win, ov, uv, hs, lsrc, lsnk} = 8'h00;
        repeat (10) @(negedge mclk);
        t_reset();
        resetn = 1'b1;
        t_start();
        t_pg();
        t_sink();
        t_src(1'b1);
        t_src(1'b0);
        t_en();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
